//--- ack_pkg.sv
// Shared constants for the acknowledge-cycle bridge and its peripheral end.
// Assumes one clock (the peripheral clock) drives both ends.
package ack_pkg;
  localparam int unsigned SHIFT_LEN  = 8;
  localparam int unsigned READ_TAP   = 3;
  localparam int unsigned WAIT_TAP   = 6;
  localparam logic [7:0]  VEC_RESET  = 8'hff;
  localparam logic [7:0]  VEC_BASE   = 8'h00;
endpackage : ack_pkg

//--- ack_link_if.sv
// Signals between the bridge and one interrupting peripheral.
// Assumes a testbench resolves the shared data bus from the enables.
`timescale 1ns/1ps
`default_nettype none
interface ack_link_if;
  logic       interrupt_ack_n;
  logic       read_n;
  logic       write_n;
  logic       chain_enable_in;
  logic       chain_enable_out;
  logic [7:0] data_out;
  logic       data_oe_n;
  modport bridge (output interrupt_ack_n, output read_n, output write_n,
                  output chain_enable_in, input chain_enable_out,
                  input data_out, input data_oe_n);
  modport periph (input interrupt_ack_n, input read_n, input write_n,
                  input chain_enable_in, output chain_enable_out,
                  output data_out, output data_oe_n);
endinterface : ack_link_if
`default_nettype wire

//--- ack_bridge.sv
// Processor-side glue generating acknowledge, read and wait strobes.
// Assumes processor bus pins arrive asynchronously; clk is the peripheral clock.
`timescale 1ns/1ps
`default_nettype none
module ack_bridge (
  input  wire logic   clk,
  input  wire logic   srst,
  input  wire logic   opcode_fetch_cycle_n,
  input  wire logic   memory_request_n,
  input  wire logic   sys_read_n,
  input  wire logic   sys_write_n,
  input  wire logic   sys_wait_n,
  input  wire logic   chain_enable_top,
  output logic        wait_n,
  output logic [7:0]  vector_data,
  output logic        vector_valid,
  output logic        chain_enable_end,
  ack_link_if.bridge  link
);
  import ack_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  logic [1:0] m1_sync_reg, m1_sync_next, memory_request_n_sync_reg, memory_request_n_sync_next;
  logic [1:0] rd_sync_reg, rd_sync_next, wr_sync_reg, wr_sync_next;
  logic [1:0] wt_sync_reg, wt_sync_next, ce_sync_reg, ce_sync_next;
  always_comb begin
    m1_sync_next   = {m1_sync_reg[0], opcode_fetch_cycle_n};
    memory_request_n_sync_next = {memory_request_n_sync_reg[0], memory_request_n};
    rd_sync_next   = {rd_sync_reg[0], sys_read_n};
    wr_sync_next   = {wr_sync_reg[0], sys_write_n};
    wt_sync_next   = {wt_sync_reg[0], sys_wait_n};
    ce_sync_next   = {ce_sync_reg[0], chain_enable_top};
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      m1_sync_reg   <= 2'h3;
      memory_request_n_sync_reg <= 2'h3;
      rd_sync_reg   <= 2'h3;
      wr_sync_reg   <= 2'h3;
      wt_sync_reg   <= 2'h3;
      ce_sync_reg   <= 2'h0;
    end else begin
      m1_sync_reg   <= m1_sync_next;
      memory_request_n_sync_reg <= memory_request_n_sync_next;
      rd_sync_reg   <= rd_sync_next;
      wr_sync_reg   <= wr_sync_next;
      wt_sync_reg   <= wt_sync_next;
      ce_sync_reg   <= ce_sync_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Acknowledge detect and shift register
  logic                 ack_cycle_detected_reg, ack_cycle_detected_next;
  logic [SHIFT_LEN-1:0] shift_reg, shift_next;
  logic                 fetch_act, memory_request_n_act;

  always_comb begin
    fetch_act = ~m1_sync_reg[1];
    memory_request_n_act  = ~memory_request_n_sync_reg[1];
    ack_cycle_detected_next = ack_cycle_detected_reg;
    if (!fetch_act) begin
      ack_cycle_detected_next = 1'b0;
    end else if (memory_request_n_act && !ack_cycle_detected_reg) begin
      ack_cycle_detected_next = 1'b0;
    end else if (!memory_request_n_act) begin
      ack_cycle_detected_next = 1'b1;
    end
    if (ack_cycle_detected_reg && fetch_act) begin
      shift_next = {shift_reg[SHIFT_LEN-2:0], 1'b1};
    end else begin
      shift_next = '0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ack_cycle_detected_reg <= 1'b0;
      shift_reg              <= '0;
    end else begin
      ack_cycle_detected_reg <= ack_cycle_detected_next;
      shift_reg              <= shift_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered strobes toward peripherals and processor
  logic ack_n_reg, ack_n_next, read_n_reg, read_n_next, write_n_reg, write_n_next;
  logic wait_n_reg, wait_n_next, ce_reg, ce_next, ceo_reg, ceo_next;
  logic [7:0] vec_reg, vec_next;
  logic vvalid_reg, vvalid_next;
  logic ack_win;

  always_comb begin
    ack_win      = shift_reg[0];
    ack_n_next   = ~ack_win;
    // Read held off until chain has settled
    read_n_next  = ack_win ? ~shift_reg[READ_TAP] : rd_sync_reg[1];
    write_n_next = ack_win ? 1'b1 : wr_sync_reg[1];
    wait_n_next  = ack_win ? shift_reg[WAIT_TAP] : wt_sync_reg[1];
    ce_next      = ce_sync_reg[1];
    ceo_next     = link.chain_enable_out;
    vvalid_next  = 1'b0;
    vec_next     = vec_reg;
    if (shift_reg[WAIT_TAP] && !shift_reg[WAIT_TAP+1] && !link.data_oe_n) begin
      vvalid_next = 1'b1;
      vec_next    = link.data_out;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ack_n_reg   <= 1'b1;
      read_n_reg  <= 1'b1;
      write_n_reg <= 1'b1;
      wait_n_reg  <= 1'b1;
      ce_reg      <= 1'b0;
      ceo_reg     <= 1'b0;
      vec_reg     <= VEC_RESET;
      vvalid_reg  <= 1'b0;
    end else begin
      ack_n_reg   <= ack_n_next;
      read_n_reg  <= read_n_next;
      write_n_reg <= write_n_next;
      wait_n_reg  <= wait_n_next;
      ce_reg      <= ce_next;
      ceo_reg     <= ceo_next;
      vec_reg     <= vec_next;
      vvalid_reg  <= vvalid_next;
    end
  end

  assign link.interrupt_ack_n = ack_n_reg;
  assign link.read_n          = read_n_reg;
  assign link.write_n         = write_n_reg;
  assign link.chain_enable_in = ce_reg;
  assign wait_n               = wait_n_reg;
  assign vector_data          = vec_reg;
  assign vector_valid         = vvalid_reg;
  assign chain_enable_end     = ceo_reg;
endmodule : ack_bridge
`default_nettype wire

//--- ack_periph.sv
// Interrupting peripheral end: daisy chain and vector register.
// Assumes strobes arrive registered on the same clock from the bridge.
`timescale 1ns/1ps
`default_nettype none
module ack_periph (
  input  wire logic   clk,
  input  wire logic   srst,
  input  wire logic   irq_req,
  input  wire logic   status_affects_vector,
  input  wire logic   vector_includes_status,
  input  wire logic   vec_wr,
  input  wire logic [7:0] vec_wr_data,
  input  wire logic [2:0] status_code,
  output logic        irq_pending,
  ack_link_if.periph  link
);
  import ack_pkg::*;

  logic [7:0] vec_reg, vec_next, out_reg, out_next;
  logic       pend_reg, pend_next, ceo_reg, ceo_next, oe_n_reg, oe_n_next;
  logic       ack, rd;

  always_comb begin
    ack       = ~link.interrupt_ack_n;
    rd        = ~link.read_n;
    vec_next  = (vec_wr && !ack) ? vec_wr_data : vec_reg;
    pend_next = irq_req | (pend_pend_hold());
    ceo_next  = ack ? (link.chain_enable_in & ~pend_reg) : link.chain_enable_in;
    // Polled read gets status regardless of options
    if (ack && (status_affects_vector || vector_includes_status)) begin
      out_next = {vec_reg[7:4], status_code, vec_reg[0]};
    end else if (!ack) begin
      out_next = {vec_reg[7:4], status_code, vec_reg[0]};
    end else begin
      out_next = vec_reg;
    end
    oe_n_next = ~(rd && (!ack || (link.chain_enable_in && pend_reg)));
  end

  function automatic logic pend_pend_hold();
    return pend_reg & ~(~link.interrupt_ack_n & ~link.read_n & link.chain_enable_in);
  endfunction : pend_pend_hold

  always_ff @(posedge clk) begin
    if (srst) begin
      vec_reg  <= VEC_BASE;
      out_reg  <= VEC_BASE;
      pend_reg <= 1'b0;
      ceo_reg  <= 1'b0;
      oe_n_reg <= 1'b1;
    end else begin
      vec_reg  <= vec_next;
      out_reg  <= out_next;
      pend_reg <= pend_next;
      ceo_reg  <= ceo_next;
      oe_n_reg <= oe_n_next;
    end
  end

  assign link.chain_enable_out = ceo_reg;
  assign link.data_out         = out_reg;
  assign link.data_oe_n        = oe_n_reg;
  assign irq_pending           = pend_reg;
endmodule : ack_periph
`default_nettype wire

//--- ack_link_chk.sv
// Checker on the signals between the bridge and the peripheral.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module ack_link_chk (
  input wire logic       clk,
  input wire logic       srst,
  input wire logic       interrupt_ack_n,
  input wire logic       read_n,
  input wire logic       write_n,
  input wire logic       chain_enable_in,
  input wire logic       chain_enable_out,
  input wire logic [7:0] data_out,
  input wire logic       data_oe_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  sequence s_ack_go;
    $fell(interrupt_ack_n);
  endsequence
  sequence s_read_go;
    $fell(read_n) && !interrupt_ack_n;
  endsequence
  read_delay_a: assert property (
    s_read_go |-> $past(!interrupt_ack_n, 3) && $past(interrupt_ack_n, 4))
    else $error("ack read strobe not three cycles after ack");
  read_hold_a: assert property (s_ack_go |-> read_n [*3])
    else $error("read strobe too early in ack");
  write_block_a: assert property (!interrupt_ack_n |-> write_n)
    else $error("write strobe during ack");
  clear_join_a: assert property ($rose(interrupt_ack_n) |-> read_n)
    else $error("read strobe left after ack end");
  reset_idle_a: assert property (
    $fell(srst) |-> interrupt_ack_n && read_n && write_n && data_oe_n)
    else $error("strobes not idle after reset");
  vec_gate_a: assert property (!data_oe_n |-> $past(!read_n))
    else $error("vector driven without read strobe");
  vec_steady_a: assert property (!data_oe_n && $past(!data_oe_n) |-> $stable(data_out))
    else $error("vector changed while driven");
  chain_block_a: assert property (!chain_enable_in |=> !chain_enable_out)
    else $error("chain enable passed without input");
endmodule : ack_link_chk
`default_nettype wire

//--- interrupt_ack_n_sync_wait_generator_tb.sv
// Bench joining bridge and peripheral across one link.
// Assumes the ack_pkg constants and the hand-over timing.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_errors++; \
  $display("[FAIL] %0t mismatch %h vs %h", $time, (a), (b)); end end
module interrupt_ack_n_sync_wait_generator_tb;
  import ack_pkg::*;
  logic       clk = 0, srst = 1, fetch_n = 1, memory_request_n_n = 1, rd_n = 1, wr_n = 1, top = 1;
  logic       wait_n, vector_valid, chain_end, irq = 0, vwr = 0, pend;
  logic [7:0] vector_data, vdat = 8'h00;
  logic [2:0] stat = 3'h0;
  logic [7:0] q[$];
  logic [7:0] exp_v;
  int         n_errors = 0, tests_run = 0, i;
  ack_link_if link();
  ack_bridge i_ack_bridge (.clk(clk), .srst(srst), .opcode_fetch_cycle_n(fetch_n),
    .memory_request_n(memory_request_n_n), .sys_read_n(rd_n), .sys_write_n(wr_n), .sys_wait_n(1'b1),
    .chain_enable_top(top), .wait_n(wait_n), .vector_data(vector_data),
    .vector_valid(vector_valid), .chain_enable_end(chain_end), .link(link));
  ack_periph i_ack_periph (.clk(clk), .srst(srst), .irq_req(irq),
    .status_affects_vector(1'b0), .vector_includes_status(1'b0), .vec_wr(vwr),
    .vec_wr_data(vdat), .status_code(stat), .irq_pending(pend), .link(link));
  ack_link_chk i_ack_link_chk (.clk(clk), .srst(srst), .interrupt_ack_n(link.interrupt_ack_n),
    .read_n(link.read_n), .write_n(link.write_n), .chain_enable_in(link.chain_enable_in),
    .chain_enable_out(link.chain_enable_out), .data_out(link.data_out),
    .data_oe_n(link.data_oe_n));
  always #12.5 clk = ~clk;
  always @(negedge clk) begin
    if (vector_valid === 1'b1) begin
      `CHK(q.size() > 0, 1'b1)
      if (q.size() > 0) begin
        exp_v = q.pop_front();
        `CHK(vector_data, exp_v)
      end
    end
  end
  task end_of_test;
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_of_test
  task ack_cycle(input logic [7:0] v);
    @(negedge clk) vdat = v;
    vwr = 1;
    irq = 1;
    @(negedge clk) vwr = 0;
    repeat (3) @(negedge clk);
    fetch_n = 0;
    q.push_back(v);
    for (i = 0; i < 40 && vector_valid !== 1'b1; i++) begin
      @(negedge clk);
      if (i == 7) `CHK(wait_n, 1'b0)
    end
    `CHK(i < 40, 1'b1)
    fetch_n = 1;
    irq = 0;
    repeat (4) @(negedge clk);
    `CHK({link.interrupt_ack_n, link.read_n, wait_n}, 3'b111)
    `CHK(pend, 1'b0)
    $display("test ack %h done", v);
  endtask : ack_cycle
  initial begin
    repeat (5000) @(posedge clk);
    n_errors++;
    end_of_test();
  end
  initial begin
    void'($urandom(90577));
    repeat (20) @(negedge clk);
    srst = 0;
    repeat (3) @(negedge clk);
    ack_cycle($urandom);
    ack_cycle($urandom);
    fetch_n = 0;
    memory_request_n_n = 0;
    repeat (12) @(negedge clk);
    `CHK({link.interrupt_ack_n, wait_n}, 2'b11)
    fetch_n = 1;
    memory_request_n_n = 1;
    stat = $urandom;
    rd_n = 0;
    for (i = 0; i < 20 && link.data_oe_n !== 1'b0; i++) @(negedge clk);
    `CHK(link.read_n, 1'b0)
    `CHK(link.data_out[3:1], stat)
    rd_n = 1;
    wr_n = 0;
    repeat (4) @(negedge clk);
    `CHK({link.write_n, link.interrupt_ack_n}, 2'b01)
    wr_n = 1;
    top = 0;
    repeat (6) @(negedge clk);
    `CHK(chain_end, 1'b0)
    top = 1;
    repeat (6) @(negedge clk);
    `CHK(chain_end, 1'b1)
    $display("test polled io done");
    end_of_test();
  end
endmodule : interrupt_ack_n_sync_wait_generator_tb
`default_nettype wire
